// file: dv/pbm_far_model.sv
// pad wires and clock divider seen by the port b mux
`timescale 1ns/10ps
module pbm_far_model (
  // clock
  input  wire logic       clk_sys_i,
  // pad controls from the mux
  input  wire logic [7:0] pad_out_i,
  input  wire logic [7:0] pad_oe_i,
  input  wire logic [7:0] pad_pullup_i,
  // external drivers, e.g. a spi master pulling select low
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  // results
  output logic      [7:0] pad_lvl_o,
  output logic            div_clk_o
);
  logic [7:0] float_q = 8'h00;
  initial div_clk_o = 1'b0;
  // undriven pins without pull-up wander every cycle
  always @(posedge clk_sys_i) begin
    float_q <= ~pad_lvl_o;
    div_clk_o <= ~div_clk_o;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe_i[i]) pad_lvl_o[i] = pad_out_i[i];
      else if (ext_en_i[i]) pad_lvl_o[i] = ext_val_i[i];
      else if (pad_pullup_i[i]) pad_lvl_o[i] = 1'b1;
      else pad_lvl_o[i] = float_q[i];
    end
  end
endmodule : pbm_far_model

// file: dv/pbm_port_b_mux_sva.sv
// concurrent checks on the port b mux outputs
`timescale 1ns/10ps
module pbm_port_b_mux_sva
  import pbm_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       srst_i,
  // controls
  input wire logic [7:0] dir_bits_i,
  input wire logic [7:0] out_bits_i,
  input wire logic       global_pullup_disable_i,
  input wire logic       sleep_clamp_i,
  input wire logic       async_timer_clock_select_i,
  input wire logic       clock_output_fuse_i,
  input wire logic       divided_clock_out_i,
  input wire logic       port_b_pinchange_group_en_i,
  input wire logic [7:0] pinchange_mask_i,
  input wire logic       spi_enable_bit_i,
  input wire logic       spi_master_select_i,
  input wire logic       timer1_compare_a_en_i,
  input wire logic       timer1_compare_a_out_i,
  input wire logic       timer1_compare_b_en_i,
  input wire logic       timer1_compare_b_out_i,
  // pads and outputs
  input wire logic [7:0] pad_in_i,
  input wire logic [7:0] pad_out_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pad_pullup_o,
  input wire logic [7:0] pad_din_en_o,
  input wire logic [7:0] dir_read_o,
  input wire logic [7:0] in_read_o,
  input wire logic       spi_slave_active_o,
  input wire logic       timer1_capture_in_o
);
  logic slv;
  logic mst;
  assign slv = spi_enable_bit_i & ~spi_master_select_i;
  assign mst = spi_enable_bit_i & spi_master_select_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence s_sel_low;
    slv && !pad_in_i[2];
  endsequence
  sequence s_cap_high;
    !sleep_clamp_i && pad_in_i[0];
  endsequence
  AST_SCK_SLAVE_IN: assert property (slv |=> !pad_oe_o[5])
    else $error("sck driven in slave mode");
  AST_MISO_MASTER_IN: assert property (mst |=> !pad_oe_o[4])
    else $error("miso driven in master mode");
  AST_MOSI_SLAVE_IN: assert property (slv |=> !pad_oe_o[3])
    else $error("mosi driven in slave mode");
  AST_SPI_PULL: assert property (slv |=> pad_pullup_o[5] ==
    $past(out_bits_i[5] && !global_pullup_disable_i))
    else $error("forced sck input pull-up wrong");
  AST_SLAVE_ACTIVE: assert property (s_sel_low [*4] |=>
    spi_slave_active_o)
    else $error("slave not active with select low");
  AST_CAPTURE: assert property (s_cap_high [*4] |=>
    timer1_capture_in_o)
    else $error("capture input missed a high pad");
  AST_CMP_A: assert property (dir_bits_i[1] && timer1_compare_a_en_i
    |=> pad_oe_o[1] && pad_out_o[1] == $past(timer1_compare_a_out_i))
    else $error("compare a not on pin 1");
  AST_CMP_B: assert property (dir_bits_i[2] && !slv &&
    timer1_compare_b_en_i |=>
    pad_oe_o[2] && pad_out_o[2] == $past(timer1_compare_b_out_i))
    else $error("compare b not on pin 2");
  AST_DIR_PIN1: assert property (1'b1 |=>
    pad_oe_o[1] == $past(dir_bits_i[1]))
    else $error("pin 1 driver differs from direction bit");
  AST_PULL_PIN1: assert property (!dir_bits_i[1] |=>
    pad_pullup_o[1] == $past(out_bits_i[1] && !global_pullup_disable_i))
    else $error("pin 1 pull-up wrong");
  AST_DIN_PIN1: assert property (!(port_b_pinchange_group_en_i &&
    pinchange_mask_i[1]) |=> pad_din_en_o[1] == !$past(sleep_clamp_i))
    else $error("pin 1 input enable ignores clamp");
  AST_TIMER_OSC: assert property (async_timer_clock_select_i |=>
    pad_oe_o[6] == 1'b0 && dir_read_o[6] == 1'b0 && in_read_o[6] == 1'b0)
    else $error("pin 6 not released to timer oscillator");
  AST_CLKOUT: assert property (disable iff (1'b0)
    clock_output_fuse_i |=>
    pad_oe_o[0] && pad_out_o[0] == $past(divided_clock_out_i))
    else $error("divided clock missing on pin 0");
endmodule : pbm_port_b_mux_sva

bind pbm_port_b_mux pbm_port_b_mux_sva chk_i (.*);

// file: dv/test_pbm_port_b_mux.sv
// self-checking bench for the port b mux
`timescale 1ns/10ps
module test_pbm_port_b_mux;
  import pbm_pkg::*;
  logic clk_sys_i, srst_i, global_pullup_disable_i, sleep_clamp_i;
  logic internal_rc_selected_i, external_clock_selected_i;
  logic async_timer_clock_select_i, external_clock_select_i;
  logic clock_output_fuse_i, divided_clock_out_i, spi_enable_bit_i;
  logic port_b_pinchange_group_en_i, spi_master_select_i;
  logic spi_sck_out_i, spi_master_out_i, spi_slave_out_i;
  logic timer2_compare_a_en_i, timer2_compare_a_out_i;
  logic timer1_compare_a_en_i, timer1_compare_a_out_i;
  logic timer1_compare_b_en_i, timer1_compare_b_out_i;
  logic [7:0] dir_bits_i, out_bits_i, pinchange_mask_i, pad_in_i;
  logic [7:0] pad_out_o, pad_oe_o, pad_pullup_o, pad_din_en_o;
  logic [7:0] dir_read_o, out_read_o, in_read_o, pinchange_in_o;
  logic spi_sck_in_o, spi_master_in_o, spi_slave_in_o;
  logic spi_slave_select_n_o, spi_slave_active_o, timer1_capture_in_o;
  logic osc_input_pin_o, osc_output_pin_o;
  logic timer_osc_input_o, timer_osc_output_o;
  logic [7:0] ext_en, ext_val;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  pbm_port_b_mux uut (.*);
  pbm_far_model far (.clk_sys_i(clk_sys_i), .pad_out_i(pad_out_o),
    .pad_oe_i(pad_oe_o), .pad_pullup_i(pad_pullup_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_lvl_o(pad_in_i),
    .div_clk_o(divided_clock_out_i));

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic step(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : step

  task automatic final_report();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 500) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    {global_pullup_disable_i, sleep_clamp_i, external_clock_selected_i,
     async_timer_clock_select_i, external_clock_select_i,
     port_b_pinchange_group_en_i, spi_enable_bit_i, spi_master_select_i,
     spi_sck_out_i, spi_master_out_i, spi_slave_out_i} = 11'h000;
    {timer2_compare_a_en_i, timer2_compare_a_out_i, timer1_compare_a_en_i,
     timer1_compare_a_out_i, timer1_compare_b_en_i,
     timer1_compare_b_out_i} = 6'h00;
    {dir_bits_i, out_bits_i, pinchange_mask_i, ext_en, ext_val} = '0;
    {srst_i, internal_rc_selected_i, clock_output_fuse_i} = 3'h7;
    step(12);
    chk("clkout oe", 8'h01, pad_oe_o[0]);
    chk("clkout", {7'h00, ~divided_clock_out_i}, pad_out_o[0]);
    srst_i = 1'b0;
    clock_output_fuse_i = 1'b0;
    dir_bits_i = 8'h0f;
    out_bits_i = 8'h35;
    step(2);
    chk("oe", 8'h0f, pad_oe_o);
    chk("pull", 8'h30, pad_pullup_o);
    global_pullup_disable_i = 1'b1;
    step(1);
    chk("pull", 8'h00, pad_pullup_o);
    // spi slave with select held low by the far master
    {global_pullup_disable_i, dir_bits_i, out_bits_i} = 17'h0ffff;
    {spi_enable_bit_i, spi_slave_out_i, ext_en, ext_val} = 18'h30c08;
    step(4);
    chk("oe", 8'hd3, pad_oe_o);
    chk("pull", 8'h2c, pad_pullup_o);
    chk("out", 8'hd3, pad_out_o);
    chk("active", 8'h01, spi_slave_active_o);
    chk("mosi in", 8'h01, spi_slave_in_o);
    chk("sck in", 8'h01, spi_sck_in_o);
    chk("ss_n", 8'h00, spi_slave_select_n_o);
    ext_val = 8'h0c;
    spi_slave_out_i = 1'b0;
    step(3);
    chk("active", 8'h00, spi_slave_active_o);
    chk("ss_n", 8'h01, spi_slave_select_n_o);
    chk("miso", 8'h00, pad_out_o[4]);
    // spi master
    {spi_master_select_i, ext_en, ext_val} = 17'h11010;
    step(4);
    chk("oe", 8'hef, pad_oe_o);
    chk("pull", 8'h10, pad_pullup_o);
    chk("out", 8'hc7, pad_out_o);
    chk("miso in", 8'h01, spi_master_in_o);
    // timer compare outputs
    {spi_enable_bit_i, spi_master_select_i, out_bits_i, ext_en} = '0;
    dir_bits_i = 8'h0e;
    {timer2_compare_a_en_i, timer2_compare_a_out_i, timer1_compare_a_en_i,
     timer1_compare_a_out_i, timer1_compare_b_en_i,
     timer1_compare_b_out_i} = 6'h3f;
    step(1);
    chk("out", 8'h0e, pad_out_o);
    dir_bits_i = 8'h00;
    step(1);
    chk("oe", 8'h00, pad_oe_o);
    {ext_en, ext_val} = 16'h0101;
    step(3);
    chk("capture", 8'h01, timer1_capture_in_o);
    chk("in rd", 8'h01, in_read_o & 8'h01);
    ext_val = 8'h00;
    step(3);
    chk("capture", 8'h00, timer1_capture_in_o);
    // input enables under sleep clamping
    sleep_clamp_i = 1'b1;
    step(1);
    chk("din", 8'h40, pad_din_en_o);
    {port_b_pinchange_group_en_i, pinchange_mask_i} = 9'h101;
    ext_val = 8'h01;
    step(3);
    chk("din", 8'h41, pad_din_en_o);
    chk("pin change", 8'h01, pinchange_in_o);
    // oscillator claims of pins 6 and 7
    {sleep_clamp_i, dir_bits_i, out_bits_i} = 17'h0ffff;
    async_timer_clock_select_i = 1'b1;
    step(1);
    chk("tosc", 8'h03, {timer_osc_input_o, timer_osc_output_o});
    chk("oe", 8'h3f, pad_oe_o);
    chk("dir rd", 8'h3f, dir_read_o);
    chk("out rd", 8'h3f, out_read_o);
    chk("in rd", 8'h00, in_read_o & 8'hc0);
    external_clock_select_i = 1'b1;
    step(1);
    chk("tosc out", 8'h00, timer_osc_output_o);
    {async_timer_clock_select_i, internal_rc_selected_i} = 2'h0;
    step(1);
    chk("osc", 8'h03, {osc_input_pin_o, osc_output_pin_o});
    chk("dir rd", 8'h3f, dir_read_o);
    external_clock_selected_i = 1'b1;
    step(1);
    chk("osc", 8'h02, {osc_input_pin_o, osc_output_pin_o});
    chk("dir rd", 8'hbf, dir_read_o);
    // divided clock output over the port bits
    {clock_output_fuse_i, dir_bits_i, out_bits_i} = 17'h10000;
    step(1);
    chk("clkout oe", 8'h01, pad_oe_o[0]);
    chk("clkout", {7'h00, ~divided_clock_out_i}, pad_out_o[0]);
    final_report();
  end
endmodule : test_pbm_port_b_mux

// file: src/pbm_pin_ctl.sv
// one pin's override combination of pull-up, driver, value and input enable
`timescale 1ns/10ps
module pbm_pin_ctl
  import pbm_pkg::*;
(
  // port register bits
  input  wire logic dir_bit_i,
  input  wire logic out_bit_i,
  input  wire logic global_pullup_disable_i,
  input  wire logic sleep_clamp_i,
  // overrides from the alternate function
  input  wire logic pullup_override_en_i,
  input  wire logic pullup_override_val_i,
  input  wire logic dir_override_en_i,
  input  wire logic dir_override_val_i,
  input  wire logic value_override_en_i,
  input  wire logic value_override_val_i,
  input  wire logic din_enable_override_en_i,
  input  wire logic din_enable_override_val_i,
  // resulting pin controls
  output logic      pullup_o,
  output logic      drive_en_o,
  output logic      drive_val_o,
  output logic      din_en_o
);

  always_comb begin
    if (pullup_override_en_i) begin
      pullup_o = pullup_override_val_i;
    end else begin
      pullup_o = ({dir_bit_i, out_bit_i, global_pullup_disable_i}
                  == PBM_PULL_PATTERN);
    end
    drive_en_o  = dir_override_en_i ? dir_override_val_i
                                    : dir_bit_i;
    // value only reaches the pad while the driver is on
    drive_val_o = value_override_en_i ? value_override_val_i
                                      : out_bit_i;
    din_en_o    = din_enable_override_en_i ? din_enable_override_val_i
                                           : ~sleep_clamp_i;
  end

endmodule : pbm_pin_ctl

// file: src/pbm_pkg.sv
// shared constants for the port b alternate function mux
package pbm_pkg;

  // pin count of the port
  localparam int unsigned PBM_PIN_NUM = 8;

  // pin positions and their alternate roles
  localparam int unsigned PBM_PIN_CAPT = 0;  // capture in, divided clock
  localparam int unsigned PBM_PIN_CMPA = 1;  // timer1 compare a
  localparam int unsigned PBM_PIN_SSEL = 2;  // slave select, timer1 cmp b
  localparam int unsigned PBM_PIN_MOSI = 3;  // mosi, timer2 compare a
  localparam int unsigned PBM_PIN_MISO = 4;
  localparam int unsigned PBM_PIN_SCK  = 5;
  localparam int unsigned PBM_PIN_OSCI = 6;  // oscillator input
  localparam int unsigned PBM_PIN_OSCO = 7;  // oscillator output

  // values after reset
  localparam logic [7:0] PBM_VEC_RST    = 8'h00;
  localparam logic       PBM_BIT_RST    = 1'b0;
  localparam logic [7:0] PBM_SYNC_RST   = 8'h00;
  // pins with the input buffer enabled while held in reset: none
  localparam logic [7:0] PBM_DIEN_RST   = 8'h00;

  // pull-up enable pattern for {dir, out, disable} without override
  localparam logic [2:0] PBM_PULL_PATTERN = 3'h2;

  // cycles from a pad change to the synchronised input
  localparam int unsigned PBM_SYNC_CYCLES = 2;
  // cycles from a control change to the pad outputs
  localparam int unsigned PBM_CTRL_CYCLES = 1;

endpackage : pbm_pkg

// file: src/pbm_port_b_mux.sv
// port b alternate function mux: overrides, pad drive and read-back
`timescale 1ns/10ps
module pbm_port_b_mux
  import pbm_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  // port registers
  input  wire logic [7:0] dir_bits_i,
  input  wire logic [7:0] out_bits_i,
  input  wire logic       global_pullup_disable_i,
  input  wire logic       sleep_clamp_i,
  // clock source and fuses
  input  wire logic       internal_rc_selected_i,
  input  wire logic       external_clock_selected_i,
  input  wire logic       async_timer_clock_select_i,
  input  wire logic       external_clock_select_i,
  input  wire logic       clock_output_fuse_i,
  input  wire logic       divided_clock_out_i,
  // pin change
  input  wire logic       port_b_pinchange_group_en_i,
  input  wire logic [7:0] pinchange_mask_i,
  // spi
  input  wire logic       spi_enable_bit_i,
  input  wire logic       spi_master_select_i,
  input  wire logic       spi_sck_out_i,
  input  wire logic       spi_master_out_i,
  input  wire logic       spi_slave_out_i,
  // timer compare outputs
  input  wire logic       timer2_compare_a_en_i,
  input  wire logic       timer2_compare_a_out_i,
  input  wire logic       timer1_compare_a_en_i,
  input  wire logic       timer1_compare_a_out_i,
  input  wire logic       timer1_compare_b_en_i,
  input  wire logic       timer1_compare_b_out_i,
  // pads
  input  wire logic [7:0] pad_in_i,
  output logic      [7:0] pad_out_o,
  output logic      [7:0] pad_oe_o,
  output logic      [7:0] pad_pullup_o,
  output logic      [7:0] pad_din_en_o,
  // register read-back
  output logic      [7:0] dir_read_o,
  output logic      [7:0] out_read_o,
  output logic      [7:0] in_read_o,
  // inputs to peripherals
  output logic            spi_sck_in_o,
  output logic            spi_master_in_o,
  output logic            spi_slave_in_o,
  output logic            spi_slave_select_n_o,
  output logic            spi_slave_active_o,
  output logic            timer1_capture_in_o,
  output logic      [7:0] pinchange_in_o,
  // oscillator claims on pins 6 and 7
  output logic            osc_input_pin_o,
  output logic            osc_output_pin_o,
  output logic            timer_osc_input_o,
  output logic            timer_osc_output_o
);

  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pull;
    logic [7:0] pad_dien;
    logic [7:0] dir_rd;
    logic [7:0] out_rd;
    logic [7:0] in_rd;
    logic       sck_in;
    logic       mst_in;
    logic       slv_in;
    logic       ss_n;
    logic       slv_act;
    logic       capt;
    logic [7:0] pcint;
    logic       osc_in;
    logic       osc_out;
    logic       tosc_in;
    logic       tosc_out;
  } pbm_state_t;

  pbm_state_t s_q;
  pbm_state_t s_d;

  // override vectors, one bit per pin
  logic [7:0] pullup_override_en;
  logic [7:0] pullup_override_val;
  logic [7:0] dir_override_en;
  logic [7:0] dir_override_val;
  logic [7:0] value_override_en;
  logic [7:0] value_override_val;
  logic [7:0] din_enable_override_en;
  logic [7:0] din_enable_override_val;

  // per-pin results
  logic [7:0] pull;
  logic [7:0] drv_en;
  logic [7:0] drv_val;
  logic [7:0] din_en;
  logic [7:0] din;
  logic [7:0] claim;

  // mode terms
  logic spi_slave;
  logic spi_master;
  logic osc7;
  logic osc6;
  logic pc_grp;
  logic pullup_allow;

  assign spi_slave  = spi_enable_bit_i & ~spi_master_select_i;
  assign spi_master = spi_enable_bit_i & spi_master_select_i;
  assign pc_grp     = port_b_pinchange_group_en_i;
  assign pullup_allow = ~global_pullup_disable_i;

  // chip oscillator on pin 7, or timer oscillator
  assign osc7 = (~internal_rc_selected_i & ~external_clock_selected_i)
              | async_timer_clock_select_i;
  assign osc6 = ~internal_rc_selected_i
              | async_timer_clock_select_i;

  // pin 7
  assign pullup_override_en[7]      = osc7;
  assign pullup_override_val[7]     = 1'b0;
  assign dir_override_en[7]         = osc7;
  assign dir_override_val[7]        = 1'b0;
  assign value_override_en[7]       = 1'b0;
  assign value_override_val[7]      = 1'b0;
  assign din_enable_override_en[7]  = osc7 | (pinchange_mask_i[7] & pc_grp);
  assign din_enable_override_val[7] = (internal_rc_selected_i
      | external_clock_selected_i)
      & ~async_timer_clock_select_i;

  // pin 6
  assign pullup_override_en[6]      = osc6;
  assign pullup_override_val[6]     = 1'b0;
  assign dir_override_en[6]         = osc6;
  assign dir_override_val[6]        = 1'b0;
  assign value_override_en[6]       = 1'b0;
  assign value_override_val[6]      = 1'b0;
  assign din_enable_override_en[6]  = internal_rc_selected_i
      | async_timer_clock_select_i
      | (pinchange_mask_i[6] & pc_grp);
  assign din_enable_override_val[6] = internal_rc_selected_i
      & ~async_timer_clock_select_i;

  // pin 5: spi clock
  assign pullup_override_en[5]      = spi_slave;
  assign pullup_override_val[5]     = out_bits_i[5] & pullup_allow;
  assign dir_override_en[5]         = spi_slave;
  assign dir_override_val[5]        = 1'b0;
  assign value_override_en[5]       = spi_master;
  assign value_override_val[5]      = spi_sck_out_i;
  assign din_enable_override_en[5]  = pinchange_mask_i[5] & pc_grp;
  assign din_enable_override_val[5] = 1'b1;

  // pin 4: miso
  assign pullup_override_en[4]      = spi_master;
  assign pullup_override_val[4]     = out_bits_i[4] & pullup_allow;
  assign dir_override_en[4]         = spi_master;
  assign dir_override_val[4]        = 1'b0;
  assign value_override_en[4]       = spi_slave;
  assign value_override_val[4]      = spi_slave_out_i;
  assign din_enable_override_en[4]  = pinchange_mask_i[4] & pc_grp;
  assign din_enable_override_val[4] = 1'b1;

  // pin 3: mosi, timer2 compare; spi master output takes priority
  assign pullup_override_en[3]      = spi_slave;
  assign pullup_override_val[3]     = out_bits_i[3] & pullup_allow;
  assign dir_override_en[3]         = spi_slave;
  assign dir_override_val[3]        = 1'b0;
  assign value_override_en[3]       = spi_master
      | timer2_compare_a_en_i;
  assign value_override_val[3]      = spi_master ? spi_master_out_i
      : timer2_compare_a_out_i;
  assign din_enable_override_en[3]  = pinchange_mask_i[3] & pc_grp;
  assign din_enable_override_val[3] = 1'b1;

  // pin 2: slave select, timer1 compare b
  assign pullup_override_en[2]      = spi_slave;
  assign pullup_override_val[2]     = out_bits_i[2] & pullup_allow;
  assign dir_override_en[2]         = spi_slave;
  assign dir_override_val[2]        = 1'b0;
  assign value_override_en[2]       = timer1_compare_b_en_i;
  assign value_override_val[2]      = timer1_compare_b_out_i;
  assign din_enable_override_en[2]  = pinchange_mask_i[2] & pc_grp;
  assign din_enable_override_val[2] = 1'b1;

  // pin 1: timer1 compare a
  assign pullup_override_en[1]      = 1'b0;
  assign pullup_override_val[1]     = 1'b0;
  assign dir_override_en[1]         = 1'b0;
  assign dir_override_val[1]        = 1'b0;
  assign value_override_en[1]       = timer1_compare_a_en_i;
  assign value_override_val[1]      = timer1_compare_a_out_i;
  assign din_enable_override_en[1]  = pinchange_mask_i[1] & pc_grp;
  assign din_enable_override_val[1] = 1'b1;

  // pin 0: capture input, divided clock output
  assign pullup_override_en[0]      = 1'b0;
  assign pullup_override_val[0]     = 1'b0;
  assign dir_override_en[0]         = clock_output_fuse_i;
  assign dir_override_val[0]        = 1'b1;
  assign value_override_en[0]       = clock_output_fuse_i;
  assign value_override_val[0]      = divided_clock_out_i;
  assign din_enable_override_en[0]  = pinchange_mask_i[0] & pc_grp;
  assign din_enable_override_val[0] = 1'b1;

  // clock pins read back as zero
  assign claim = {osc7, osc6, 6'h00};

  genvar gi;
  generate
    for (gi = 0; gi < PBM_PIN_NUM; gi++) begin : g_pin
      pbm_pin_ctl u_pin (
        .dir_bit_i                 (dir_bits_i[gi]),
        .out_bit_i                 (out_bits_i[gi]),
        .global_pullup_disable_i   (global_pullup_disable_i),
        .sleep_clamp_i             (sleep_clamp_i),
        .pullup_override_en_i      (pullup_override_en[gi]),
        .pullup_override_val_i     (pullup_override_val[gi]),
        .dir_override_en_i         (dir_override_en[gi]),
        .dir_override_val_i        (dir_override_val[gi]),
        .value_override_en_i       (value_override_en[gi]),
        .value_override_val_i      (value_override_val[gi]),
        .din_enable_override_en_i  (din_enable_override_en[gi]),
        .din_enable_override_val_i (din_enable_override_val[gi]),
        .pullup_o                  (pull[gi]),
        .drive_en_o                (drv_en[gi]),
        .drive_val_o               (drv_val[gi]),
        .din_en_o                  (din_en[gi])
      );
    end
  endgenerate

  // disabled inputs are clamped low
  assign din = s_q.sync2 & din_en;

  always_comb begin
    s_d          = s_q;
    s_d.sync1    = pad_in_i;
    s_d.sync2    = s_q.sync1;
    s_d.pad_oe   = drv_en;
    // a released driver shows a low value
    s_d.pad_out  = drv_val & drv_en;
    s_d.pad_pull = pull & ~drv_en;
    s_d.pad_dien = din_en;
    s_d.dir_rd   = dir_bits_i & ~claim;
    s_d.out_rd   = out_bits_i & ~claim;
    s_d.in_rd    = din & ~claim;
    s_d.sck_in   = din[PBM_PIN_SCK];
    s_d.mst_in   = spi_master & din[PBM_PIN_MISO];
    s_d.slv_in   = spi_slave & din[PBM_PIN_MOSI];
    s_d.ss_n     = din[PBM_PIN_SSEL];
    s_d.slv_act  = spi_slave & ~din[PBM_PIN_SSEL];
    s_d.capt     = din[PBM_PIN_CAPT];
    s_d.pcint    = din & pinchange_mask_i;
    s_d.osc_in   = ~internal_rc_selected_i
                 & ~async_timer_clock_select_i;
    s_d.osc_out  = ~internal_rc_selected_i & ~external_clock_selected_i
                 & ~async_timer_clock_select_i;
    s_d.tosc_in  = async_timer_clock_select_i;
    s_d.tosc_out = async_timer_clock_select_i
                 & ~external_clock_select_i;
    if (srst_i) begin
      s_d.sync1    = PBM_SYNC_RST;
      s_d.sync2    = PBM_SYNC_RST;
      s_d.pad_out  = PBM_VEC_RST;
      s_d.pad_oe   = PBM_VEC_RST;
      s_d.pad_pull = PBM_VEC_RST;
      s_d.pad_dien = PBM_DIEN_RST;
      s_d.dir_rd   = PBM_VEC_RST;
      s_d.out_rd   = PBM_VEC_RST;
      s_d.in_rd    = PBM_VEC_RST;
      s_d.sck_in   = PBM_BIT_RST;
      s_d.mst_in   = PBM_BIT_RST;
      s_d.slv_in   = PBM_BIT_RST;
      s_d.ss_n     = ~PBM_BIT_RST;
      s_d.slv_act  = PBM_BIT_RST;
      s_d.capt     = PBM_BIT_RST;
      s_d.pcint    = PBM_VEC_RST;
      s_d.osc_in   = PBM_BIT_RST;
      s_d.osc_out  = PBM_BIT_RST;
      s_d.tosc_in  = PBM_BIT_RST;
      s_d.tosc_out = PBM_BIT_RST;
      // divided clock keeps running through reset
      s_d.pad_oe[PBM_PIN_CAPT]  = clock_output_fuse_i;
      s_d.pad_out[PBM_PIN_CAPT] = clock_output_fuse_i
                                & divided_clock_out_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    s_q <= s_d;
  end

  assign pad_out_o            = s_q.pad_out;
  assign pad_oe_o             = s_q.pad_oe;
  assign pad_pullup_o         = s_q.pad_pull;
  assign pad_din_en_o         = s_q.pad_dien;
  assign dir_read_o           = s_q.dir_rd;
  assign out_read_o           = s_q.out_rd;
  assign in_read_o            = s_q.in_rd;
  assign spi_sck_in_o         = s_q.sck_in;
  assign spi_master_in_o      = s_q.mst_in;
  assign spi_slave_in_o       = s_q.slv_in;
  assign spi_slave_select_n_o = s_q.ss_n;
  assign spi_slave_active_o   = s_q.slv_act;
  assign timer1_capture_in_o  = s_q.capt;
  assign pinchange_in_o       = s_q.pcint;
  assign osc_input_pin_o      = s_q.osc_in;
  assign osc_output_pin_o     = s_q.osc_out;
  assign timer_osc_input_o    = s_q.tosc_in;
  assign timer_osc_output_o   = s_q.tosc_out;

endmodule : pbm_port_b_mux
